/* File: dcdcc_pkg.sv */
// shared constants for the converter control register block
package dcdcc_pkg;

    // register placement on the special-function register space
    localparam logic [7:0] DCDCC_SFR_PAGE    = 8'h00;
    localparam logic [7:0] DCDCC_CTRL_ADDR   = 8'h97;
    localparam logic [7:0] DCDCC_CTRL_RESET  = 8'h21;

    // field positions inside dcdc_control
    localparam int         DCDCC_MPW_MSB     = 7;
    localparam int         DCDCC_MPW_LSB     = 6;
    localparam int         DCDCC_SWSZ_BIT    = 5;
    localparam int         DCDCC_RSVD_BIT    = 4;
    localparam int         DCDCC_LOCK_BIT    = 3;
    localparam int         DCDCC_OLVL_MSB    = 2;
    localparam int         DCDCC_OLVL_LSB    = 0;

    // writable bits; the reserved bit always reads zero
    localparam logic [7:0] DCDCC_CTRL_WMASK  = 8'hef;

    // minimum pulse width codes
    typedef enum logic [1:0] {
        DCDCC_MPW_NONE = 2'h0,
        DCDCC_MPW_20   = 2'h1,
        DCDCC_MPW_40   = 2'h2,
        DCDCC_MPW_80   = 2'h3
    } dcdcc_mpw_t;

    // pulse widths in ns and their cycle counts at the system clock
    localparam int         DCDCC_MCLK_PERIOD_NS = 20;
    localparam int         DCDCC_MPW_20_NS      = 20;
    localparam int         DCDCC_MPW_40_NS      = 40;
    localparam int         DCDCC_MPW_80_NS      = 80;
    localparam logic [2:0] DCDCC_MPW_20_CYC     =
        3'((DCDCC_MPW_20_NS + DCDCC_MCLK_PERIOD_NS - 1) / DCDCC_MCLK_PERIOD_NS);
    localparam logic [2:0] DCDCC_MPW_40_CYC     =
        3'((DCDCC_MPW_40_NS + DCDCC_MCLK_PERIOD_NS - 1) / DCDCC_MCLK_PERIOD_NS);
    localparam logic [2:0] DCDCC_MPW_80_CYC     =
        3'((DCDCC_MPW_80_NS + DCDCC_MCLK_PERIOD_NS - 1) / DCDCC_MCLK_PERIOD_NS);
    localparam logic [2:0] DCDCC_MPW_NONE_CYC   = 3'h0;

    // target output level in millivolts per code
    localparam logic [11:0] DCDCC_VOUT_MV [0:7] = '{
        12'h708, 12'h76c, 12'h7d0, 12'h834,
        12'h960, 12'ha8c, 12'hbb8, 12'hce4
    };
    localparam logic [11:0] DCDCC_VOUT_RESET_MV = 12'h76c;

    // lockstep phase measurement
    localparam int          DCDCC_PHASE_W       = 8;
    localparam logic [7:0]  DCDCC_PHASE_MAX     = 8'hff;
    localparam logic [7:0]  DCDCC_PHASE_ONE     = 8'h01;
    localparam logic [7:0]  DCDCC_PHASE_ZERO    = 8'h00;

    typedef enum logic [2:0] {
        DCDCC_LS_OFF    = 3'b001,
        DCDCC_LS_ACQ    = 3'b010,
        DCDCC_LS_LOCKED = 3'b100
    } dcdcc_ls_state_t;

endpackage

/* File: dcdcc_lockstep.sv */
`timescale 1ns/1ns
// converter-synchronous adc tracking window and sar clock
module dcdcc_lockstep
    import dcdcc_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_rst,
    input  wire logic i_enable,
    input  wire logic i_dcdc_clk,
    output logic      o_track,
    output logic      o_sar_clk,
    output logic      o_locked
);

    typedef struct packed {
        logic                     sync1;
        logic                     sync2;
        logic                     last;
        dcdcc_ls_state_t          state;
        logic [1:0]               rises;
        logic [DCDCC_PHASE_W-1:0] hi_cnt;
        logic [DCDCC_PHASE_W-1:0] lo_cnt;
        logic [DCDCC_PHASE_W-1:0] hi_len;
        logic [DCDCC_PHASE_W-1:0] lo_len;
        logic                     track;
        logic                     sar;
    } dcdcc_ls_t;

    dcdcc_ls_t ls_r;
    dcdcc_ls_t ls_nxt;
    logic      rise;
    logic      fall;

    // edges come from the second stage only, never the first
    assign rise = ls_r.sync2 & ~ls_r.last;
    assign fall = ~ls_r.sync2 & ls_r.last;

    // phase measurement and quiet-interval selection
    always_comb begin
        ls_nxt       = ls_r;
        ls_nxt.sync1 = i_dcdc_clk;
        ls_nxt.sync2 = ls_r.sync1;
        ls_nxt.last  = ls_r.sync2;
        // saturate so a stalled converter clock cannot wrap the count
        if (ls_r.sync2) begin
            if (ls_r.hi_cnt != DCDCC_PHASE_MAX) ls_nxt.hi_cnt = ls_r.hi_cnt + DCDCC_PHASE_ONE;
        end else begin
            if (ls_r.lo_cnt != DCDCC_PHASE_MAX) ls_nxt.lo_cnt = ls_r.lo_cnt + DCDCC_PHASE_ONE;
        end
        if (rise) begin
            ls_nxt.lo_len = ls_r.lo_cnt;
            ls_nxt.lo_cnt = DCDCC_PHASE_ZERO;
        end
        if (fall) begin
            ls_nxt.hi_len = ls_r.hi_cnt;
            ls_nxt.hi_cnt = DCDCC_PHASE_ZERO;
        end
        unique case (ls_r.state)
            DCDCC_LS_OFF: begin
                ls_nxt.rises = 2'h0;
                if (i_enable) ls_nxt.state = DCDCC_LS_ACQ;
            end
            DCDCC_LS_ACQ: begin
                // two rises bracket one complete switching cycle
                if (rise) ls_nxt.rises = ls_r.rises + 2'h1;
                if (rise && ls_r.rises == 2'h1) ls_nxt.state = DCDCC_LS_LOCKED;
                if (!i_enable) ls_nxt.state = DCDCC_LS_OFF;
            end
            DCDCC_LS_LOCKED: begin
                if (!i_enable) ls_nxt.state = DCDCC_LS_OFF;
            end
            default: ls_nxt.state = DCDCC_LS_OFF;
        endcase
        // track during the longer of the two phases of the cycle
        if (ls_r.state == DCDCC_LS_LOCKED && i_enable) begin
            ls_nxt.track = (ls_r.lo_len >= ls_r.hi_len) ? ~ls_r.sync2 : ls_r.sync2;
        end else begin
            ls_nxt.track = 1'b0;
        end
        // sar clock follows the converter clock, so it stays in step with it
        ls_nxt.sar = i_enable ? ls_r.sync2 : 1'b0;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ls_r <= '{state: DCDCC_LS_OFF, default: '0};
        end else begin
            ls_r <= ls_nxt;
        end
    end

    assign o_track   = ls_r.track;
    assign o_sar_clk = ls_r.sar;
    assign o_locked  = (ls_r.state == DCDCC_LS_LOCKED);

endmodule // dcdcc_lockstep

/* File: dcdcc_ctrl.sv */
`timescale 1ns/1ns
// What this block does
// - control register, page 0x0, address 0x97, read/write
// - bits 7:6 select minimum pulse width
// - bit 5 clear large switches, set small
// - lockstep clear runs adc independently
// - lockstep set syncs tracking and sar clock
// - bits 2:0 select target output level
// - level codes map 1.8 V to 3.3 V
module dcdcc_ctrl
    import dcdcc_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // special-function register access
    input  wire logic [7:0]  i_sfr_page,
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_sfr_wdata,
    output logic      [7:0]  o_sfr_rdata,
    output logic             o_sfr_sel,
    // converter controls
    output logic      [1:0]  o_min_pulse_width_sel,
    output logic      [2:0]  o_min_pulse_cycles,
    output logic             o_switch_size_sel,
    output logic             o_large_switch_en,
    output logic             o_small_switch_en,
    output logic      [2:0]  o_output_level_sel,
    output logic      [11:0] o_target_mv,
    // analog converter timing
    input  wire logic        i_dcdc_clk,
    input  wire logic        i_adc_track_req,
    input  wire logic        i_adc_sar_clk,
    input  wire logic [4:0]  i_adc_clock_prescale,
    output logic             o_adc_track,
    output logic             o_adc_sar_clk,
    output logic             o_adc_lockstep,
    output logic             o_lockstep_locked,
    output logic             o_prescale_conflict
);

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  rdata;
        logic [2:0]  mpw_cyc;
        logic [11:0] target_mv;
        logic        track;
        logic        sar;
        logic        conflict;
    } dcdcc_state_t;

    dcdcc_state_t st_r;
    dcdcc_state_t st_nxt;
    logic         hit;
    logic         lock_en;
    logic         ls_track;
    logic         ls_sar;
    logic         ls_locked;
    dcdcc_mpw_t   mpw_code;

    // address decode on page and address together
    assign hit      = (i_sfr_page == DCDCC_SFR_PAGE) && (i_sfr_addr == DCDCC_CTRL_ADDR);
    assign lock_en  = st_r.ctrl[DCDCC_LOCK_BIT];
    assign mpw_code = dcdcc_mpw_t'(st_r.ctrl[DCDCC_MPW_MSB:DCDCC_MPW_LSB]);

    // lockstep timing runs only while the lockstep bit is set
    dcdcc_lockstep u_lockstep (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_enable  (lock_en),
        .i_dcdc_clk(i_dcdc_clk),
        .o_track   (ls_track),
        .o_sar_clk (ls_sar),
        .o_locked  (ls_locked)
    );

    // register write, read capture and derived controls
    always_comb begin
        st_nxt = st_r;
        // reserved bit is masked so it always reads back as zero
        if (i_sfr_wr && hit) begin
            st_nxt.ctrl = i_sfr_wdata & DCDCC_CTRL_WMASK;
        end
        // read data valid the cycle after the strobe; zero when not selected
        if (i_sfr_rd && hit) begin
            st_nxt.rdata = st_r.ctrl;
        end else begin
            st_nxt.rdata = 8'h00;
        end
        // pulse width code to a count of system clock cycles
        unique case (mpw_code)
            DCDCC_MPW_NONE: st_nxt.mpw_cyc = DCDCC_MPW_NONE_CYC;
            DCDCC_MPW_20:   st_nxt.mpw_cyc = DCDCC_MPW_20_CYC;
            DCDCC_MPW_40:   st_nxt.mpw_cyc = DCDCC_MPW_40_CYC;
            DCDCC_MPW_80:   st_nxt.mpw_cyc = DCDCC_MPW_80_CYC;
        endcase
        // level code to millivolts for the regulation loop
        st_nxt.target_mv = DCDCC_VOUT_MV[st_r.ctrl[DCDCC_OLVL_MSB:DCDCC_OLVL_LSB]];
        // adc path: free running unless lockstep is enabled
        if (lock_en) begin
            st_nxt.track = ls_track;
            st_nxt.sar   = ls_sar;
        end else begin
            st_nxt.track = i_adc_track_req;
            st_nxt.sar   = i_adc_sar_clk;
        end
        // software must zero the prescale in lockstep; flag it if it forgot while the lockstep bit is set
        st_nxt.conflict = lock_en && (i_adc_clock_prescale != 5'h00);
    end

    // one register stage holds all state outside the lockstep unit
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '{ctrl: DCDCC_CTRL_RESET, target_mv: DCDCC_VOUT_RESET_MV, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the register fields, except o_sfr_sel from the live address decode and o_lockstep_locked from the lockstep state
    assign o_sfr_rdata           = st_r.rdata;
    assign o_sfr_sel             = hit;
    assign o_min_pulse_width_sel = st_r.ctrl[DCDCC_MPW_MSB:DCDCC_MPW_LSB];
    assign o_min_pulse_cycles    = st_r.mpw_cyc;
    assign o_switch_size_sel     = st_r.ctrl[DCDCC_SWSZ_BIT];
    assign o_large_switch_en     = ~st_r.ctrl[DCDCC_SWSZ_BIT];
    assign o_small_switch_en     = st_r.ctrl[DCDCC_SWSZ_BIT];
    assign o_output_level_sel    = st_r.ctrl[DCDCC_OLVL_MSB:DCDCC_OLVL_LSB];
    assign o_target_mv           = st_r.target_mv;
    assign o_adc_track           = st_r.track;
    assign o_adc_sar_clk         = st_r.sar;
    assign o_adc_lockstep        = lock_en;
    assign o_lockstep_locked     = ls_locked;
    assign o_prescale_conflict   = st_r.conflict;

endmodule // dcdcc_ctrl

/* File: dcdcc_ctrl_assertions.sv */
`timescale 1ns/1ns
// port-level checks of the converter control register
module dcdcc_ctrl_assertions
    import dcdcc_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_sfr_page,
    input wire logic [7:0]  i_sfr_addr,
    input wire logic        i_sfr_wr,
    input wire logic        i_sfr_rd,
    input wire logic [7:0]  i_sfr_wdata,
    input wire logic        i_adc_track_req,
    input wire logic [4:0]  i_adc_clock_prescale,
    input wire logic        i_dcdc_clk,
    input wire logic        o_adc_sar_clk,
    input wire logic [7:0]  o_sfr_rdata,
    input wire logic        o_sfr_sel,
    input wire logic [1:0]  o_min_pulse_width_sel,
    input wire logic [2:0]  o_min_pulse_cycles,
    input wire logic        o_switch_size_sel,
    input wire logic        o_large_switch_en,
    input wire logic        o_small_switch_en,
    input wire logic [2:0]  o_output_level_sel,
    input wire logic [11:0] o_target_mv,
    input wire logic        o_adc_track,
    input wire logic        o_adc_lockstep,
    input wire logic        o_lockstep_locked,
    input wire logic        o_prescale_conflict
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // decoded strobes; reserved bit 4 is taken as zero in every field compare
    wire hit_wr = i_sfr_wr && o_sfr_sel;
    wire hit_rd = i_sfr_rd && o_sfr_sel;
    wire [7:0] ctrl_view = {o_min_pulse_width_sel, o_switch_size_sel, 1'b0, o_adc_lockstep, o_output_level_sel};
    chk_addr_decode: assert property (o_sfr_sel == (i_sfr_page == 8'h00 && i_sfr_addr == 8'h97))
        else $error("register decode wrong");
    chk_write_fields: assert property (hit_wr |=> ctrl_view == ($past(i_sfr_wdata) & 8'hef))
        else $error("written fields not taken");
    chk_read_hit: assert property (hit_rd && !i_sfr_wr |=> o_sfr_rdata == ctrl_view)
        else $error("read data differs from register");
    chk_read_idle: assert property (!hit_rd |=> o_sfr_rdata == 8'h00)
        else $error("read data not zero without hit");
    chk_pulse_cycles: assert property (1'b1 |=> o_min_pulse_cycles ==
        ($past(o_min_pulse_width_sel) == 2'h3 ? 3'h4 : {1'b0, $past(o_min_pulse_width_sel)}))
        else $error("pulse cycles wrong");
    chk_target_level: assert property (1'b1 |=> o_target_mv == DCDCC_VOUT_MV[$past(o_output_level_sel)])
        else $error("target level wrong");
    chk_switch_pair: assert property (o_small_switch_en == o_switch_size_sel &&
        o_large_switch_en == !o_switch_size_sel)
        else $error("switch enables wrong");
    chk_prescale_flag: assert property (o_adc_lockstep && i_adc_clock_prescale != 5'h00 |=> o_prescale_conflict)
        else $error("prescale conflict not flagged");
    chk_track_free: assert property (!o_adc_lockstep ##1 !o_adc_lockstep |->
        o_adc_track == $past(i_adc_track_req))
        else $error("free track not passed through");
    // sar clock: two sync stages, lockstep stage and output stage behind the pin
    chk_sar_follow: assert property (o_adc_lockstep ##1 o_adc_lockstep |=>
        o_adc_sar_clk == $past(i_dcdc_clk, 4))
        else $error("lockstep sar clock not in step");
    cover property (hit_wr);
    cover property (hit_rd ##1 o_sfr_rdata != 8'h00);
    cover property ($rose(o_lockstep_locked));
endmodule // dcdcc_ctrl_assertions

bind dcdcc_ctrl dcdcc_ctrl_assertions u_dcdcc_ctrl_assertions (.*);

/* File: dcdcc_ctrl_test.sv */
`timescale 1ns/1ns
// self-checking bench for the converter control register
module dcdcc_ctrl_test;
    import dcdcc_pkg::*;
    logic        i_mclk = 0, i_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_dcdc_clk = 0, i_adc_track_req = 0;
    logic        i_adc_sar_clk = 0, rd_seen = 0, o_sfr_sel, o_switch_size_sel, o_large_switch_en;
    logic        o_small_switch_en, o_adc_track, o_adc_sar_clk, o_adc_lockstep, o_lockstep_locked;
    logic        o_prescale_conflict;
    logic [7:0]  i_sfr_page = 0, i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata, seed = 8'h18, v;
    logic [4:0]  i_adc_clock_prescale = 0;
    logic [1:0]  o_min_pulse_width_sel;
    logic [2:0]  o_min_pulse_cycles, o_output_level_sel;
    logic [11:0] o_target_mv;
    logic [7:0]  exp_q [$];
    int          num_errors = 0, checks = 0, n;
    localparam logic [11:0] exp_mv [0:7] = '{12'h708, 12'h76c, 12'h7d0, 12'h834, 12'h960, 12'ha8c, 12'hbb8, 12'hce4};

    dcdcc_ctrl u_dcdcc_ctrl (.*);

    always #10 i_mclk = ~i_mclk;

    // random source, fixed start
    function automatic logic [7:0] next_rand();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    // automatic, so the read watcher and the main flow can never share arguments
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wrap_up();
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one cycle of access; strobes are not dropped here, so they stay driven until the next call
    task acc(input logic [7:0] pg, ad, input bit wr, rd, input logic [7:0] wd, ex);
        i_sfr_page = pg;
        i_sfr_addr = ad;
        i_sfr_wr = wr;
        i_sfr_rd = rd;
        i_sfr_wdata = wd;
        if (rd)
            exp_q.push_back(ex);
        @(negedge i_mclk);
    endtask

    // read data lands one cycle after the strobe; misses are noted as zero
    always @(posedge i_mclk) rd_seen <= i_sfr_rd;
    always @(negedge i_mclk) begin
        if (rd_seen)
            check(o_sfr_rdata, exp_q.pop_front());
    end

    initial begin
        repeat (20) @(negedge i_mclk);
        i_rst = 0;
        acc(8'h00, 8'h97, 0, 1, 8'h00, 8'h21);
        acc(8'h00, 8'h00, 0, 0, 8'h00, 8'h00);
        check(o_target_mv, 12'h76c);
        check({o_large_switch_en, o_small_switch_en}, 2'h1);
        // every level and pulse code, random switch, lockstep and reserved bits
        for (int i = 0; i < 8; i++) begin
            v = next_rand();
            v = {i[1:0], v[5:3], i[2:0]};
            acc(8'h00, 8'h97, 1, 0, v, 8'h00);
            acc(8'h00, 8'h97, 0, 1, 8'h00, v & 8'hef);
            acc(8'h00, 8'h00, 0, 0, 8'h00, 8'h00);
            check(o_target_mv, exp_mv[i]);
            check(o_min_pulse_cycles, i[1:0] == 2'h3 ? 3'h4 : {1'b0, i[1:0]});
            check(o_large_switch_en, !v[5]);
            check(o_adc_lockstep, v[3]);
        end
        // misses leave the register alone; same-cycle read returns the old value
        acc(8'h01, 8'h97, 1, 1, 8'h00, 8'h00);
        acc(8'h00, 8'h96, 1, 1, 8'h00, 8'h00);
        acc(8'h00, 8'h97, 1, 1, 8'h48, v & 8'hef);
        acc(8'h00, 8'h97, 0, 1, 8'h00, 8'h48);
        i_adc_clock_prescale = 5'h03;
        acc(8'h00, 8'h00, 0, 0, 8'h00, 8'h00);
        acc(8'h00, 8'h00, 0, 0, 8'h00, 8'h00);
        check(o_prescale_conflict, 1'b1);
        i_adc_clock_prescale = 5'h00;
        // converter clock high 2, low 6: tracking must sit in the low phase
        for (n = 0; n < 40 && o_lockstep_locked !== 1'b1; n++) begin
            i_dcdc_clk = 1;
            repeat (2) @(negedge i_mclk);
            i_dcdc_clk = 0;
            repeat (6) @(negedge i_mclk);
        end
        if (n == 40) begin
            num_errors++;
            wrap_up();
        end
        n = 0;
        for (int k = 0; k < 24; k++) begin
            i_dcdc_clk = (k % 8) < 2;
            @(negedge i_mclk);
            if (k >= 16)
                n += o_adc_track;
        end
        check(n, 6);
        acc(8'h00, 8'h97, 1, 0, 8'h21, 8'h00);
        acc(8'h00, 8'h00, 0, 0, 8'h00, 8'h00);
        acc(8'h00, 8'h00, 0, 0, 8'h00, 8'h00);
        check(o_lockstep_locked, 1'b0);
        for (int k = 0; k < 6; k++) begin
            v = next_rand();
            i_adc_track_req = v[0];
            i_adc_sar_clk = v[1];
            @(negedge i_mclk);
            check({o_adc_track, o_adc_sar_clk}, {v[0], v[1]});
        end
        // reset in mid-run restores the reset value
        acc(8'h00, 8'h97, 1, 0, 8'hc6, 8'h00);
        i_rst = 1;
        acc(8'h00, 8'h00, 0, 0, 8'h00, 8'h00);
        i_rst = 0;
        acc(8'h00, 8'h97, 0, 1, 8'h00, 8'h21);
        acc(8'h00, 8'h00, 0, 0, 8'h00, 8'h00);
        @(negedge i_mclk);
        wrap_up();
    end
endmodule // dcdcc_ctrl_test
